// *** verilog/crs_defs.svh ***
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
// register file shape
`define CRS_XLEN        32
`define CRS_NREGS       32
`define CRS_GPR_INIT    32'h00000000
// dedicated register numbers
`define CRS_REG_ZERO    5'h00
`define CRS_REG_IRQ_RET 5'h0e
`define CRS_REG_BRK_RET 5'h10
`define CRS_REG_EXC_RET 5'h11
// special register selectors
`define CRS_SEL_PC      14'h0000
`define CRS_SEL_MSR     14'h0001
// reset values
`define CRS_PC_RESET    32'h00000000
`define CRS_MSR_RESET   32'h00000000
`define CRS_WORD_ZERO   32'h00000000
// status bit positions, msb-first numbering
`define CRS_MSR_CC      0
`define CRS_MSR_PVR     21
`define CRS_MSR_C       29
// bits 17..30 except 21 are writable
`define CRS_MSR_WMASK   32'h00007bfe
// barrier operand bits
`define CRS_MBAR_DATA   0
`define CRS_MBAR_INSTR  1
// reservation word address slice
`define CRS_RESV_LSB    2
`endif

// *** verilog/crs_pkg.sv ***
package crs_pkg;
  typedef logic [31:0] crs_word_t;
  typedef logic [0:31] crs_msr_t;
  typedef logic [4:0]  crs_regidx_t;
  typedef logic [13:0] crs_sel_t;
  typedef logic [4:0]  crs_mbop_t;
  typedef enum logic [0:0] {
    crs_mb_idle  = 1'b0,
    crs_mb_drain = 1'b1
  } crs_mbar_e;
endpackage

// *** verilog/crs_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.svh"
module crs_regfile #(
  parameter int NREGS = `CRS_NREGS,
  parameter int W     = `CRS_XLEN
) (
  input  wire logic         mclk,
  input  wire logic         wr_en,
  input  wire logic [4:0]   wr_addr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [4:0]   rd_addr_a,
  input  wire logic [4:0]   rd_addr_b,
  output logic      [W-1:0] rd_data_a,
  output logic      [W-1:0] rd_data_b
);
  logic [W-1:0] mem [NREGS];

  // contents come up zero at configuration load only
  initial begin
    for (int i = 0; i < NREGS; i++) begin
      mem[i] = `CRS_GPR_INIT;
    end
  end

  // no reset input at all, so runtime resets leave contents intact
  always_ff @(posedge mclk) begin
    if (wr_en && wr_addr != `CRS_REG_ZERO) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered reads, register zero forced to zero
  always_ff @(posedge mclk) begin
    rd_data_a <= (rd_addr_a == `CRS_REG_ZERO) ? '0 : mem[rd_addr_a];
    rd_data_b <= (rd_addr_b == `CRS_REG_ZERO) ? '0 : mem[rd_addr_b];
  end

  zero_read_a: assert property (@(posedge mclk)
    rd_addr_a == `CRS_REG_ZERO |=> rd_data_a == '0)
    else $error("register zero read nonzero");
endmodule
`default_nettype wire

// *** verilog/crs_msr.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.svh"
module crs_msr #(
  parameter bit PVR_PRESENT = 1'b0
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              soft_rst,
  input  wire logic              mts_wr,
  input  wire crs_pkg::crs_msr_t mts_data,
  input  wire logic              set_en,
  input  wire logic              clr_en,
  input  wire crs_pkg::crs_msr_t bit_mask,
  input  wire logic              carry_wr_en,
  input  wire logic              carry_wr_val,
  output crs_pkg::crs_msr_t      msr_view,
  output logic                   carry
);
  import crs_pkg::*;
  crs_msr_t bits;
  logic     carry_q;
  logic     next_carry;

  // next carry: move-to, store result, then set or clear win
  always_comb begin
    next_carry = carry_q;
    if (mts_wr) next_carry = mts_data[`CRS_MSR_C];
    if (carry_wr_en) next_carry = carry_wr_val;
    if (set_en && bit_mask[`CRS_MSR_C]) next_carry = 1'b1;
    if (clr_en && bit_mask[`CRS_MSR_C]) next_carry = 1'b0;
  end
  // carry output: set/clear seen at once, move-to and store a cycle later
  always_comb begin
    carry = carry_q;
    if (set_en && bit_mask[`CRS_MSR_C]) carry = 1'b1;
    if (clr_en && bit_mask[`CRS_MSR_C]) carry = 1'b0;
  end

  // carry state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) carry_q <= 1'b0;
    else if (soft_rst) carry_q <= 1'b0;
    else carry_q <= next_carry;
  end

  // other bits change one cycle after set, clear or move
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) bits <= `CRS_MSR_RESET;
    else if (soft_rst) bits <= `CRS_MSR_RESET;
    else if (mts_wr) bits <= mts_data & `CRS_MSR_WMASK;
    else if (set_en) bits <= bits | (bit_mask & `CRS_MSR_WMASK);
    else if (clr_en) bits <= bits & ~(bit_mask & `CRS_MSR_WMASK);
  end

  // read view: carry mirrored into bit 0, written bit 0 dropped
  always_comb begin
    msr_view = bits;
    msr_view[`CRS_MSR_C] = carry_q;
    msr_view[`CRS_MSR_CC] = carry_q;
    msr_view[`CRS_MSR_PVR] = PVR_PRESENT;
  end

  carry_copy_a: assert property (@(posedge mclk) disable iff (rst)
    msr_view[`CRS_MSR_CC] == msr_view[`CRS_MSR_C])
    else $error("carry copy differs from carry");
  mts_delay_a: assert property (@(posedge mclk) disable iff (rst)
    mts_wr && !soft_rst |=> ((msr_view & `CRS_MSR_WMASK)
      == ($past(mts_data) & `CRS_MSR_WMASK)))
    else $error("status write not visible next cycle");
  set_carry_a: assert property (@(posedge mclk) disable iff (rst)
    set_en && bit_mask[`CRS_MSR_C] && !clr_en |-> carry)
    else $error("carry set not immediate");
endmodule
`default_nettype wire

// *** verilog/crs_core_state.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.svh"
module crs_core_state #(
  parameter bit HW_EXC_EN   = 1'b1,
  parameter bit PVR_PRESENT = 1'b0
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 sys_reset_in,
  input  wire logic                 core_reset_in,
  input  wire logic                 debug_reset_in,
  input  wire logic                 pc_advance,
  input  wire crs_pkg::crs_word_t   pc_next,
  output crs_pkg::crs_word_t        program_counter,
  input  wire crs_pkg::crs_regidx_t rd_addr_a,
  input  wire crs_pkg::crs_regidx_t rd_addr_b,
  output crs_pkg::crs_word_t        rd_data_a,
  output crs_pkg::crs_word_t        rd_data_b,
  input  wire logic                 wr_en,
  input  wire crs_pkg::crs_regidx_t wr_addr,
  input  wire crs_pkg::crs_word_t   wr_data,
  input  wire logic                 irq_take,
  input  wire logic                 brk_take,
  input  wire logic                 exc_take,
  input  wire crs_pkg::crs_word_t   ret_addr,
  input  wire crs_pkg::crs_word_t   exc_next_addr,
  input  wire logic                 exc_in_delay_slot,
  input  wire crs_pkg::crs_word_t   branch_target_reg,
  input  wire logic                 lwx_exec,
  input  wire crs_pkg::crs_word_t   lwx_addr,
  input  wire logic                 swx_exec,
  output logic                      swx_store_en,
  output logic                      reservation_valid,
  input  wire logic                 mts_en,
  input  wire crs_pkg::crs_sel_t    special_reg_selector,
  input  wire crs_pkg::crs_word_t   mts_data,
  input  wire logic                 mfs_en,
  input  wire crs_pkg::crs_sel_t    special_reg_selector_read,
  output crs_pkg::crs_word_t        mfs_data,
  input  wire logic                 status_bits_set,
  input  wire logic                 status_bits_clear,
  input  wire crs_pkg::crs_word_t   status_mask,
  output crs_pkg::crs_msr_t         machine_status_reg,
  output logic                      carry,
  input  wire logic                 mbar_exec,
  input  wire crs_pkg::crs_mbop_t   mbar_op,
  input  wire logic                 writes_pending,
  output logic                      mbar_stall,
  output logic                      prefetch_flush,
  output logic                      btc_clear
);
  import crs_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // reset pins from outside the clock domain
  logic [2:0] rpin_meta;
  logic [2:0] rpin_sync;
  logic       soft_rst;

  // two flops per pin before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rpin_meta <= 3'h0;
      rpin_sync <= 3'h0;
    end else begin
      rpin_meta <= {debug_reset_in, core_reset_in, sys_reset_in};
      rpin_sync <= rpin_meta;
    end
  end
  assign soft_rst = |rpin_sync;

  //////////////////////////////////////////////////////////////////////
  // program counter
  crs_word_t pc;

  // only the fetch path and the resets load it; a move-to never does
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc <= `CRS_PC_RESET;
    end else if (soft_rst) begin
      pc <= `CRS_PC_RESET;
    end else if (pc_advance) begin
      pc <= pc_next;
    end
  end
  assign program_counter = pc;

  //////////////////////////////////////////////////////////////////////
  // load-reserve reservation
  logic       resv_valid;
  logic [29:0] resv_addr;
  logic       trap_event;

  assign trap_event = irq_take | brk_take | exc_take;

  // traps and resets win over a reserving load in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resv_valid <= 1'b0;
    end else if (soft_rst || trap_event) begin
      resv_valid <= 1'b0;
    end else if (swx_exec) begin
      resv_valid <= 1'b0;
    end else if (lwx_exec) begin
      resv_valid <= 1'b1;
    end
  end

  // one word-granular address, replaced by each reserving load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resv_addr <= '0;
    end else if (lwx_exec && !trap_event && !swx_exec) begin
      resv_addr <= lwx_addr[31:`CRS_RESV_LSB];
    end
  end

  // store goes ahead on any reservation, address match not needed
  assign swx_store_en = swx_exec & resv_valid;
  assign reservation_valid = resv_valid;

  //////////////////////////////////////////////////////////////////////
  // register file write port with trap return addresses
  logic        rf_wr_en;
  crs_regidx_t rf_wr_addr;
  crs_word_t   rf_wr_data;

  // exception over break over interrupt over pipeline write
  always_comb begin
    rf_wr_en   = wr_en;
    rf_wr_addr = wr_addr;
    rf_wr_data = wr_data;
    if (exc_take && HW_EXC_EN) begin
      rf_wr_en   = 1'b1;
      rf_wr_addr = `CRS_REG_EXC_RET;
      rf_wr_data = exc_in_delay_slot ? branch_target_reg
                                     : exc_next_addr;
    end else if (brk_take) begin
      rf_wr_en   = 1'b1;
      rf_wr_addr = `CRS_REG_BRK_RET;
      rf_wr_data = ret_addr;
    end else if (irq_take) begin
      rf_wr_en   = 1'b1;
      rf_wr_addr = `CRS_REG_IRQ_RET;
      rf_wr_data = ret_addr;
    end
  end

  crs_regfile #(
    .NREGS (`CRS_NREGS),
    .W     (`CRS_XLEN)
  ) u_rf (
    .mclk      (mclk),
    .wr_en     (rf_wr_en),
    .wr_addr   (rf_wr_addr),
    .wr_data   (rf_wr_data),
    .rd_addr_a (rd_addr_a),
    .rd_addr_b (rd_addr_b),
    .rd_data_a (rd_data_a),
    .rd_data_b (rd_data_b)
  );

  //////////////////////////////////////////////////////////////////////
  // machine status register
  logic     mts_msr;
  crs_msr_t msr_view;

  // selector one picks the status register; selector zero is dropped
  assign mts_msr = mts_en && special_reg_selector == `CRS_SEL_MSR;

  crs_msr #(
    .PVR_PRESENT (PVR_PRESENT)
  ) u_msr (
    .mclk         (mclk),
    .rst          (rst),
    .soft_rst     (soft_rst),
    .mts_wr       (mts_msr),
    .mts_data     (mts_data),
    .set_en       (status_bits_set),
    .clr_en       (status_bits_clear),
    .bit_mask     (status_mask),
    .carry_wr_en  (swx_exec),
    .carry_wr_val (~resv_valid),
    .msr_view     (msr_view),
    .carry        (carry)
  );
  assign machine_status_reg = msr_view;

  //////////////////////////////////////////////////////////////////////
  // move-from-special read port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mfs_data <= `CRS_WORD_ZERO;
    end else if (mfs_en) begin
      unique case (special_reg_selector_read)
        `CRS_SEL_PC:  mfs_data <= pc;
        `CRS_SEL_MSR: mfs_data <= msr_view;
        default:      mfs_data <= `CRS_WORD_ZERO;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // memory barrier
  crs_mbar_e mb_state;
  logic      mb_instr_pend;
  logic      mb_data;
  logic      mb_instr;
  logic      mb_fire;

  assign mb_data  = mbar_exec & mbar_op[`CRS_MBAR_DATA];
  assign mb_instr = mbar_exec & mbar_op[`CRS_MBAR_INSTR];

  // data barrier holds the pipeline while writes drain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mb_state <= crs_mb_idle;
    end else if (soft_rst) begin
      mb_state <= crs_mb_idle;
    end else begin
      unique case (mb_state)
        crs_mb_idle:
          if (mb_data && writes_pending) mb_state <= crs_mb_drain;
        crs_mb_drain:
          if (!writes_pending) mb_state <= crs_mb_idle;
      endcase
    end
  end

  // an instruction flush queued behind a draining data barrier
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mb_instr_pend <= 1'b0;
    end else if (soft_rst) begin
      mb_instr_pend <= 1'b0;
    end else if (mb_state == crs_mb_idle) begin
      mb_instr_pend <= mb_instr && mb_data && writes_pending;
    end else if (!writes_pending) begin
      mb_instr_pend <= 1'b0;
    end
  end

  assign mbar_stall = (mb_state == crs_mb_drain) ||
                      (mb_data && writes_pending);

  // flush fires when nothing is left to wait for
  assign mb_fire = (mb_state == crs_mb_idle) ?
                   (mb_instr && !(mb_data && writes_pending)) :
                   (mb_instr_pend && !writes_pending);

  // one-cycle flush pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prefetch_flush <= 1'b0;
      btc_clear      <= 1'b0;
    end else begin
      prefetch_flush <= mb_fire && !soft_rst;
      btc_clear      <= mb_fire && !soft_rst;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  resv_trap_a: assert property (
    trap_event |=> !resv_valid)
    else $error("reservation survived a trap");
  resv_swx_a: assert property (
    swx_exec |=> !resv_valid)
    else $error("conditional store left reservation");
  swx_carry_a: assert property (
    swx_exec && !status_bits_set && !status_bits_clear
      |-> swx_store_en == resv_valid ##1 carry == !$past(resv_valid))
    else $error("conditional store result wrong");
  lwx_addr_a: assert property (
    lwx_exec && !trap_event && !swx_exec && !soft_rst
      |=> resv_valid && resv_addr == $past(lwx_addr[31:2]))
    else $error("reservation address not replaced");
  irq_ret_a: assert property (
    irq_take && !brk_take && !exc_take
      |-> rf_wr_en && rf_wr_addr == 5'h0e
          && rf_wr_data == ret_addr)
    else $error("interrupt return not in register 14");
  brk_ret_a: assert property (
    brk_take && !exc_take
      |-> rf_wr_en && rf_wr_addr == 5'h10
          && rf_wr_data == ret_addr)
    else $error("break return not in register 16");
  exc_ret_a: assert property (
    exc_take && HW_EXC_EN && exc_in_delay_slot
      |-> rf_wr_addr == 5'h11
          && rf_wr_data == branch_target_reg)
    else $error("delay slot exception return wrong");
  pc_read_a: assert property (
    mfs_en && special_reg_selector_read == 14'h0000
      |=> mfs_data == $past(pc))
    else $error("pc read not own address");
  pc_reset_a: assert property (
    soft_rst |=> pc == 32'h00000000)
    else $error("pc not reset to zero");
  msr_read_a: assert property (
    mfs_en && special_reg_selector_read == 14'h0001
      |=> mfs_data[31] == mfs_data[2])
    else $error("status read carry copy missing");
  mbar_wait_a: assert property (
    mb_data && writes_pending |-> mbar_stall ##1 mbar_stall)
    else $error("data barrier did not wait");
  mbar_flush_a: assert property (
    mb_instr && !mb_data && !soft_rst
      |=> prefetch_flush && btc_clear)
    else $error("instruction barrier did not flush");
  resv_rst_a: assert property (
    soft_rst |=> !resv_valid)
    else $error("reservation survived a reset");
  pc_hold_a: assert property (
    !pc_advance && !soft_rst |=> pc == $past(pc))
    else $error("program counter moved without fetch");
  flush_idle_a: assert property (
    !mbar_exec && mb_state == crs_mb_idle |=> !prefetch_flush)
    else $error("flush without a barrier");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crs_pkg::*;
  logic        mclk, rst, sys_reset_in, core_reset_in, debug_reset_in;
  logic        pc_advance, wr_en, irq_take, brk_take, exc_take;
  logic        exc_in_delay_slot, lwx_exec, swx_exec, mts_en, mfs_en;
  logic        status_bits_set, status_bits_clear, mbar_exec;
  logic        writes_pending, swx_store_en, reservation_valid, carry;
  logic        mbar_stall, prefetch_flush, btc_clear;
  crs_word_t   pc_next, program_counter, rd_data_a, rd_data_b, wr_data;
  crs_word_t   ret_addr, exc_next_addr, branch_target_reg, lwx_addr;
  crs_word_t   mts_data, mfs_data, status_mask;
  crs_regidx_t rd_addr_a, rd_addr_b, wr_addr;
  crs_sel_t    special_reg_selector, special_reg_selector_read;
  crs_msr_t    machine_status_reg;
  crs_mbop_t   mbar_op;
  int          fail_count;
  int          n_tests;

  crs_core_state #(.HW_EXC_EN(1'b1), .PVR_PRESENT(1'b0)) u_crs_core_state (
    .mclk, .rst, .sys_reset_in, .core_reset_in, .debug_reset_in,
    .pc_advance, .pc_next, .program_counter, .rd_addr_a, .rd_addr_b,
    .rd_data_a, .rd_data_b, .wr_en, .wr_addr, .wr_data, .irq_take,
    .brk_take, .exc_take, .ret_addr, .exc_next_addr, .exc_in_delay_slot,
    .branch_target_reg, .lwx_exec, .lwx_addr, .swx_exec, .swx_store_en,
    .reservation_valid, .mts_en, .special_reg_selector, .mts_data, .mfs_en,
    .special_reg_selector_read, .mfs_data, .status_bits_set,
    .status_bits_clear, .status_mask, .machine_status_reg, .carry,
    .mbar_exec, .mbar_op, .writes_pending, .mbar_stall, .prefetch_flush,
    .btc_clear
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input crs_regidx_t a, input crs_word_t d);
    @(posedge mclk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // registered read on both ports, data one edge after the address
  task automatic rd(input crs_regidx_t a, input crs_word_t exp);
    @(posedge mclk);
    rd_addr_a <= a;
    rd_addr_b <= a;
    @(posedge mclk);
    #1;
    chk("rd_data_a", exp, rd_data_a);
    chk("rd_data_b", exp, rd_data_b);
  endtask

  task automatic mfs(input crs_sel_t s, input crs_word_t exp);
    @(posedge mclk);
    mfs_en                    <= 1'b1;
    special_reg_selector_read <= s;
    @(posedge mclk);
    mfs_en <= 1'b0;
    #1;
    chk("mfs_data", exp, mfs_data);
  endtask

  // move-to: status must hold its old view until the edge that takes it
  task automatic mts(input crs_sel_t s, input crs_word_t d,
                     input crs_word_t old, input crs_word_t exp);
    @(posedge mclk);
    mts_en               <= 1'b1;
    special_reg_selector <= s;
    mts_data             <= d;
    #1;
    chk("msr before edge", old, machine_status_reg);
    chk("carry before edge", {31'h0, old[2]}, {31'h0, carry});
    @(posedge mclk);
    mts_en <= 1'b0;
    #1;
    chk("msr after edge", exp, machine_status_reg);
    chk("carry after edge", {31'h0, exp[2]}, {31'h0, carry});
  endtask

  // set or clear: carry moves at once, the status view one edge later
  task automatic sc(input logic set, input crs_word_t m, input logic c,
                    input crs_word_t old, input crs_word_t exp);
    @(posedge mclk);
    status_bits_set   <= set;
    status_bits_clear <= !set;
    status_mask       <= m;
    #1;
    chk("carry at once", {31'h0, c}, {31'h0, carry});
    chk("msr before edge", old, machine_status_reg);
    @(posedge mclk);
    status_bits_set   <= 1'b0;
    status_bits_clear <= 1'b0;
    #1;
    chk("msr after edge", exp, machine_status_reg);
  endtask

  task automatic lwx(input crs_word_t a);
    @(posedge mclk);
    lwx_exec <= 1'b1;
    lwx_addr <= a;
    @(posedge mclk);
    lwx_exec <= 1'b0;
    #1;
    chk("reservation_valid", 32'h1, {31'h0, reservation_valid});
  endtask

  task automatic swx(input logic held);
    @(posedge mclk);
    swx_exec <= 1'b1;
    #1;
    chk("swx_store_en", {31'h0, held}, {31'h0, swx_store_en});
    @(posedge mclk);
    swx_exec <= 1'b0;
    #1;
    chk("reservation_valid", 32'h0, {31'h0, reservation_valid});
    chk("carry", {31'h0, !held}, {31'h0, carry});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd(5'd20, 32'h00000000);
    wr(5'd31, 32'ha5a5_0f0f);
    wr(5'd0, 32'hffff_ffff);
    rd(5'd31, 32'ha5a5_0f0f);
    rd(5'd0, 32'h00000000);
    $display("test regs done");
  endtask

  task automatic t_status;
    mts(14'h0001, 32'h8000_0002, 32'h0, 32'h0000_0002);
    mfs(14'h0001, 32'h0000_0002);
    mts(14'h0001, 32'h0001_0006, 32'h2, 32'h8000_0006);
    mfs(14'h0001, 32'h8000_0006);
    sc(1'b0, 32'h0000_0006, 1'b0, 32'h8000_0006, 32'h0);
    sc(1'b1, 32'h0000_0006, 1'b1, 32'h0, 32'h8000_0006);
    $display("test status done");
  endtask

  task automatic t_pc;
    @(posedge mclk);
    pc_advance <= 1'b1;
    pc_next    <= 32'h0000_0100;
    @(posedge mclk);
    pc_advance <= 1'b0;
    #1;
    chk("program_counter", 32'h0000_0100, program_counter);
    mfs(14'h0000, 32'h0000_0100);
    mts(14'h0000, 32'hdead_beef, 32'h8000_0006, 32'h8000_0006);
    chk("program_counter", 32'h0000_0100, program_counter);
    mfs(14'h0005, 32'h0);
    $display("test pc done");
  endtask

  task automatic t_resv;
    lwx(32'h0000_0040);
    lwx(32'h0000_0080);
    swx(1'b1);
    swx(1'b0);
    $display("test reservation done");
  endtask

  // interrupt, break, exception, exception in a delay slot
  task automatic t_traps;
    crs_word_t exp;
    for (int k = 0; k < 4; k++) begin
      lwx(32'h0000_0100);
      @(posedge mclk);
      ret_addr          <= 32'h0000_2000 + k;
      exc_next_addr     <= 32'h0000_3000 + k;
      branch_target_reg <= 32'h0000_4000 + k;
      exc_in_delay_slot <= (k == 3);
      irq_take          <= (k == 0);
      brk_take          <= (k == 1);
      exc_take          <= (k >= 2);
      @(posedge mclk);
      irq_take <= 1'b0;
      brk_take <= 1'b0;
      exc_take <= 1'b0;
      #1;
      chk("reservation_valid", 32'h0, {31'h0, reservation_valid});
      exp = (k < 2) ? 32'h0000_2000 + k :
            (k == 2) ? 32'h0000_3002 : 32'h0000_4003;
      rd((k == 0) ? 5'd14 : (k == 1) ? 5'd16 : 5'd17, exp);
    end
    $display("test traps done");
  endtask

  // each runtime reset pin clears state but keeps the register file
  task automatic t_rstpins;
    for (int k = 0; k < 3; k++) begin
      wr(5'(3 + k), 32'hcafe_0000 + k);
      lwx(32'h0000_0200);
      @(posedge mclk);
      pc_advance     <= 1'b1;
      pc_next        <= 32'h0000_0400;
      sys_reset_in   <= (k == 0);
      core_reset_in  <= (k == 1);
      debug_reset_in <= (k == 2);
      @(posedge mclk);
      pc_advance     <= 1'b0;
      sys_reset_in   <= 1'b0;
      core_reset_in  <= 1'b0;
      debug_reset_in <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      chk("reservation_valid", 32'h0, {31'h0, reservation_valid});
      chk("program_counter", 32'h0, program_counter);
      rd(5'(3 + k), 32'hcafe_0000 + k);
    end
    $display("test reset pins done");
  endtask

  task automatic t_barrier;
    @(posedge mclk);
    mbar_exec      <= 1'b1;
    mbar_op        <= 5'h01;
    writes_pending <= 1'b1;
    #1;
    chk("mbar_stall", 32'h1, {31'h0, mbar_stall});
    @(posedge mclk);
    mbar_exec <= 1'b0;
    #1;
    chk("mbar_stall", 32'h1, {31'h0, mbar_stall});
    chk("prefetch_flush", 32'h0, {31'h0, prefetch_flush});
    @(posedge mclk);
    writes_pending <= 1'b0;
    @(posedge mclk);
    #1;
    chk("mbar_stall", 32'h0, {31'h0, mbar_stall});
    // software order: data barrier first, then the instruction flush
    @(posedge mclk);
    mbar_exec <= 1'b1;
    mbar_op   <= 5'h02;
    @(posedge mclk);
    mbar_exec <= 1'b0;
    #1;
    chk("flush pulse", 32'h3, {30'h0, prefetch_flush, btc_clear});
    @(posedge mclk);
    #1;
    chk("flush end", 32'h0, {30'h0, prefetch_flush, btc_clear});
    // both barriers at once: the flush waits for the drain to end
    @(posedge mclk);
    mbar_exec      <= 1'b1;
    mbar_op        <= 5'h03;
    writes_pending <= 1'b1;
    @(posedge mclk);
    mbar_exec <= 1'b0;
    @(posedge mclk);
    writes_pending <= 1'b0;
    #1;
    chk("flush held", 32'h0, {30'h0, prefetch_flush, btc_clear});
    @(posedge mclk);
    #1;
    chk("flush late", 32'h3, {30'h0, prefetch_flush, btc_clear});
    $display("test barrier done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("Error run limit expected end seen hang");
    results();
  end

  // main sequence
  initial begin
    {rst, sys_reset_in, core_reset_in, debug_reset_in} = 4'h8;
    {pc_advance, wr_en, irq_take, brk_take, exc_take} = 5'h00;
    {exc_in_delay_slot, lwx_exec, swx_exec, mts_en, mfs_en} = 5'h00;
    {status_bits_set, status_bits_clear, mbar_exec, writes_pending} = 4'h0;
    {pc_next, wr_data, ret_addr, exc_next_addr} = 128'h0;
    {branch_target_reg, lwx_addr, mts_data, status_mask} = 128'h0;
    {rd_addr_a, rd_addr_b, wr_addr, mbar_op} = 20'h00000;
    {special_reg_selector, special_reg_selector_read} = 28'h0000000;
    fail_count = 0;
    n_tests    = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_status();
    t_pc();
    t_resv();
    t_traps();
    t_rstpins();
    t_barrier();
    results();
  end
endmodule
`default_nettype wire
